/* File: bench/cmh_core_model.sv */
// Purpose: Behavioural protocol core standing for the other CAN nodes
// Assumes: Core events are one-cycle pulses on pclk
// Notes:   Every offered frame is acknowledged DONE_DLY cycles after the start pulse ends
`timescale 1ns/1ps
module cmh_core_model
#(
  parameter int DONE_DLY = 3
)
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // Transmit side
  input  wire logic           tx_req,
  output logic                tx_start,
  output logic                tx_done,
  output logic                tx_abort,
  // Receive side
  output logic                rx_valid,
  output cmh_pkg::cmh_frame_s rx_frame
);
  // Transmit answers; start only while a frame is offered
  initial
  begin
    {tx_start, tx_done, tx_abort, rx_valid} = 4'h0;
    rx_frame = '0;
    forever
    begin
      @(posedge pclk);
      if (presetn && tx_req)
      begin
        tx_start <= 1'b1;
        @(posedge pclk);
        tx_start <= 1'b0;
        repeat (DONE_DLY) @(posedge pclk);
        tx_done <= 1'b1;             // Bus acknowledged the frame
        @(posedge pclk);
        tx_done <= 1'b0;
        repeat (2) @(posedge pclk);  // Handler needs a gap before re-offer
      end
    end
  end

  // One received frame; lines then show the inverse, never stale data
  task automatic send(input cmh_pkg::cmh_frame_s f);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the message object handler
// Assumes: Zero-wait APB; object n maps to bit n-1 of the pending vectors
// Notes:   Table of APB steps first, then a mid-run reset
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [1:0]  ev;  // 1 data frame first, 2 remote frame first, 3 error
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;   // Write data or expected read data
  } cmh_row_s;
  localparam cmh_pkg::cmh_frame_s DFRM = '{{11'h155, 18'h2aaaa}, 1'b0, 1'b0, 4'h8,
                                           64'h0807060504030201};
  localparam cmh_pkg::cmh_frame_s RFRM = '{{11'h0f0, 18'h0}, 1'b0, 1'b1, 4'h0, 64'h0};
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                rx_valid, tx_start, tx_done, tx_abort, tx_req, er;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd;
  cmh_pkg::cmh_frame_s rx_frame, txf;
  logic [5:0]          txo;
  cmh_row_s            rows[$];
  int                  err_total, n_compared, ntx;

  cmh_top #(.NOBJ(32)) cmh_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_start(tx_start), .tx_done(tx_done), .tx_abort(tx_abort), .tx_req(tx_req),
    .tx_frame(txf), .tx_obj(txo));
  cmh_core_model cmh_core_model_inst (.pclk(pclk), .presetn(presetn), .tx_req(tx_req),
    .tx_start(tx_start), .tx_done(tx_done), .tx_abort(tx_abort), .rx_valid(rx_valid),
    .rx_frame(rx_frame));

  // 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %0t flag %b expected %b", $time, g, e);
    end
  endtask

  // Expected offers: object 1 first, then the remote answer of object 3
  wire [31:0] tx_exp = (ntx == 0) ? {10'h000, 6'h01, 11'h123, 1'b0, 4'h8}
                                  : {10'h000, 6'h03, 11'h0f0, 1'b0, 4'h8};

  // Offered frame as the core loads it
  always @(posedge pclk)
    if (tx_start)
    begin
      cmp32({10'h000, txo, txf.id[28:18], txf.rtr, txf.dlc}, tx_exp);
      ntx++;
    end

  // Request held until pready is seen high at a rising edge; only the guard ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic r(input int e, input int w, input logic [7:0] a, input logic [31:0] d);
    rows.push_back('{e[1:0], w[0], a, d});
  endtask

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge pclk);
    err_total++;
    $display("[FAIL] %0t run did not finish", $time);
    print_verdict();
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, err_total, n_compared, ntx} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    cmp1(pready, 1'b0);
    cmp1(tx_req, 1'b0);
    presetn <= 1'b1;
    r(0, 1, 8'h14, 32'h44332211); r(0, 1, 8'h18, 32'h88776655);
    r(0, 1, 8'h08, 32'h0); r(0, 1, 8'h0c, 32'ha48c0000);
    r(0, 1, 8'h10, 32'h0888); r(0, 1, 8'h04, 32'hf3); r(0, 1, 8'h00, 32'h1);
    r(0, 1, 8'h14, 32'ha5a5a5a5); r(0, 1, 8'h04, 32'h87);
    r(0, 1, 8'h00, 32'h1); r(0, 0, 8'h24, 32'h1);
    r(0, 0, 8'h1c, 32'h0); r(0, 1, 8'h04, 32'h7f);
    r(0, 1, 8'h00, 32'h1); r(0, 0, 8'h14, 32'ha5a5a5a5);
    r(0, 1, 8'h0c, 32'h85540000); r(0, 1, 8'h10, 32'h0480);
    r(0, 1, 8'h04, 32'hf3); r(0, 1, 8'h00, 32'h2);
    r(1, 0, 8'h20, 32'h2); r(0, 0, 8'h24, 32'h2);
    r(0, 1, 8'h04, 32'h7f); r(0, 1, 8'h00, 32'h2);
    r(0, 0, 8'h0c, 32'h85540000);
    r(0, 0, 8'h10, 32'ha488);
    r(0, 0, 8'h14, 32'h04030201); r(0, 0, 8'h18, 32'h08070605);
    r(0, 0, 8'h20, 32'h0); r(0, 0, 8'h24, 32'h0);
    r(1, 0, 8'h20, 32'h2); r(1, 1, 8'h00, 32'h2);
    r(0, 0, 8'h10, 32'he488); r(0, 1, 8'h00, 32'h2);
    r(0, 0, 8'h10, 32'h4488);
    r(0, 1, 8'h0c, 32'ha3c00000); r(0, 1, 8'h10, 32'h0a88);
    r(0, 1, 8'h04, 32'hf3); r(0, 1, 8'h00, 32'h3);
    r(2, 0, 8'h24, 32'h4);
    r(0, 1, 8'h0c, 32'h85540000); r(0, 1, 8'h10, 32'h0008);
    r(0, 1, 8'h00, 32'h2); r(0, 1, 8'h10, 32'h0088);
    r(0, 1, 8'h00, 32'h4);
    r(1, 0, 8'h20, 32'h2); r(1, 0, 8'h20, 32'ha);
    r(1, 1, 8'h04, 32'h7f); r(0, 1, 8'h00, 32'h2);
    r(0, 0, 8'h10, 32'h8008); r(0, 1, 8'h00, 32'h4);
    r(0, 0, 8'h10, 32'hc088); r(0, 0, 8'h20, 32'h0);
    r(3, 0, 8'h30, 32'h0);
    foreach (rows[i])
    begin
      if (rows[i].ev == 2'h1) cmh_core_model_inst.send(DFRM);
      if (rows[i].ev == 2'h2) cmh_core_model_inst.send(RFRM);
      repeat (12) @(posedge pclk);
      apb(rows[i].wr, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].wr) cmp32(rd, rows[i].d);
      cmp1(er, rows[i].ev == 2'h3);
    end
    // Mid-run reset clears every stored pending flag
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h24, 32'h0, rd, er);
    cmp32(rd, 32'h0);
    print_verdict();
  end
endmodule

/* File: rtl/cmh_defs.svh */
// Purpose: Offsets, field positions and reset values of the message handler
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Included by the match and top modules; definitions only
`ifndef CMH_DEFS_SVH
`define CMH_DEFS_SVH

// -----------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------
`define CMH_A_CREQ    8'h00
`define CMH_A_CMASK   8'h04
`define CMH_A_MASK    8'h08
`define CMH_A_ARB     8'h0c
`define CMH_A_MCON    8'h10
`define CMH_A_DATA_A  8'h14
`define CMH_A_DATA_B  8'h18
`define CMH_A_TXPEND  8'h1c
`define CMH_A_NDPEND  8'h20
`define CMH_A_IPPEND  8'h24

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define CMH_CREQ_BUSY 15
`define CMH_CM_WR     7
`define CMH_CM_MASK   6
`define CMH_CM_ARB    5
`define CMH_CM_CTRL   4
`define CMH_CM_CLRIP  3
`define CMH_CM_TXND   2
`define CMH_CM_DA     1
`define CMH_CM_DB     0
`define CMH_MC_NEW_DATA_FLAG 15
`define CMH_MC_MESSAGE_LOST_FLAG 14
`define CMH_MC_INTERRUPT_PENDING_FLAG 13
`define CMH_MC_USE_ACCEPTANCE_MASK  12
`define CMH_MC_TRANSMIT_INT_ENABLE   11
`define CMH_MC_RECEIVE_INT_ENABLE   10
`define CMH_MC_REMOTE_ANSWER_ENABLE  9
`define CMH_MC_TRANSMIT_REQUEST 8
`define CMH_MC_EOB    7
`define CMH_AR_VALID  31
`define CMH_AR_XTD    30
`define CMH_AR_DIR    29
`define CMH_MK_MASK_EXTENDED_FLAG   31
`define CMH_MK_MASK_DIRECTION_FLAG   30

// -----------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------
`define CMH_RST_CMASK 8'h00
`define CMH_RST_WORD  32'h0000_0000

`endif

/* File: rtl/cmh_match.sv */
// Purpose: Acceptance compare of one message object against one frame
// Assumes: Mask bit 1 means the bit is compared
// Notes:   Purely combinational, one instance per object
`timescale 1ns/1ps
`include "cmh_defs.svh"
module cmh_match
(
  // Object and frame
  input  cmh_pkg::cmh_obj_s   obj,
  input  cmh_pkg::cmh_frame_s frm,
  // Result
  output logic                hit
);

  // -----------------------------------------------------------------------
  // Compare
  // -----------------------------------------------------------------------
  // Mask applies only with the object's mask enable
  wire        use_acceptance_mask  = obj.mcon[`CMH_MC_USE_ACCEPTANCE_MASK];
  wire [28:0] idm    = use_acceptance_mask ? obj.mask[28:0] : {29{1'b1}};
  wire [28:0] stdm   = frm.xtd ? {29{1'b1}} : {{11{1'b1}}, 18'h0_0000};
  wire        id_ok  = ((obj.arb[28:0] ^ frm.id) & idm & stdm) == 29'h0;
  wire        xtd_ok = (obj.arb[`CMH_AR_XTD] == frm.xtd) | (use_acceptance_mask & ~obj.mask[`CMH_MK_MASK_EXTENDED_FLAG]);
  wire        dir_ok = (obj.arb[`CMH_AR_DIR] == frm.rtr) | (use_acceptance_mask & ~obj.mask[`CMH_MK_MASK_DIRECTION_FLAG]);

  assign hit = obj.arb[`CMH_AR_VALID] & id_ok & xtd_ok & dir_ok;

endmodule

/* File: rtl/cmh_pkg.sv */
// Purpose: Types shared by the message handler modules
// Assumes: Field positions come from cmh_defs.svh
// Notes:   Frames travel as packed structs
package cmh_pkg;

  // Stored message object
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] arb;
    logic [15:0] mcon;
    logic [31:0] da;
    logic [31:0] db;
  } cmh_obj_s;

  // Frame between handler and protocol core; data byte 0 in bits 7:0
  typedef struct packed {
    logic [28:0] id;
    logic        xtd;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cmh_frame_s;

  typedef enum logic [2:0] {OP_NONE, OP_XFER, OP_DONE, OP_START, OP_RX} cmh_op_e;
  typedef enum logic {ST_IDLE, ST_BUSY} cmh_state_e;

endpackage

/* File: rtl/cmh_top.sv */
// Purpose: CAN message object handler with one interface buffer on APB
// Assumes: Protocol core on pclk, gives one-cycle rx/tx event pulses
// Notes:   One message RAM update per cycle; core events queue meanwhile
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "cmh_defs.svh"
module cmh_top
#(
  parameter int NOBJ = 32
)
(
  // Clock and reset
  input  logic                      pclk,
  input  logic                      presetn,
  // APB slave
  input  logic                      psel,
  input  logic                      penable,
  input  logic                      pwrite,
  input  logic [7:0]                paddr,
  input  logic [31:0]               pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Receive side of the protocol core
  input  logic                      rx_valid,
  input  cmh_pkg::cmh_frame_s       rx_frame,
  // Transmit side of the protocol core
  input  logic                      tx_start,
  input  logic                      tx_done,
  input  logic                      tx_abort,
  output logic                      tx_req,
  output cmh_pkg::cmh_frame_s       tx_frame,
  output logic [$clog2(NOBJ):0]     tx_obj
);

  localparam int IW = $clog2(NOBJ);
  localparam int NW = IW + 1;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  cmh_pkg::cmh_obj_s    mem [NOBJ];
  cmh_pkg::cmh_obj_s    ifb_r;
  cmh_pkg::cmh_obj_s    ifb_nxt;
  cmh_pkg::cmh_obj_s    cur;
  cmh_pkg::cmh_obj_s    nxt;
  cmh_pkg::cmh_frame_s  rx_r;
  cmh_pkg::cmh_frame_s  tx_frame_r;
  cmh_pkg::cmh_state_e  state_r;
  cmh_pkg::cmh_op_e     op;
  logic [7:0]           cmask_r;
  logic [NW-1:0]        creq_num_r;
  logic [NW-1:0]        tx_num_r;
  logic [IW-1:0]        txo_r;
  logic [IW-1:0]        idx;
  logic [IW-1:0]        idx_q;
  logic [31:0]          prdata_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic                 rx_pend_r;
  logic                 st_pend_r;
  logic                 dn_pend_r;
  logic                 inflight_r;
  logic                 tx_req_r;
  logic                 wr_en;
  logic [NOBJ-1:0]      hit;
  logic [NOBJ-1:0]      txp;
  logic [NOBJ-1:0]      ndv;
  logic [NOBJ-1:0]      ipv;
  logic [NOBJ-1:0]      elig;

  // Lowest set bit wins; returns {found, index}
  function automatic logic [IW:0] first_set(input logic [NOBJ-1:0] v);
    logic [IW:0] r;
    r = '0;
    for (int i = NOBJ - 1; i >= 0; i--)
      if (v[i]) r = {1'b1, IW'(i)};
    return r;
  endfunction

  // -----------------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------------
  wire setup     = psel & ~penable;
  wire acc       = psel & penable & pready_r;
  wire busy      = state_r == cmh_pkg::ST_BUSY;
  wire sel_creq  = paddr == `CMH_A_CREQ;
  wire sel_cmask = paddr == `CMH_A_CMASK;
  wire sel_mask  = paddr == `CMH_A_MASK;
  wire sel_arb   = paddr == `CMH_A_ARB;
  wire sel_mcon  = paddr == `CMH_A_MCON;
  wire sel_da    = paddr == `CMH_A_DATA_A;
  wire sel_db    = paddr == `CMH_A_DATA_B;
  wire sel_txp   = paddr == `CMH_A_TXPEND;
  wire sel_ndp   = paddr == `CMH_A_NDPEND;
  wire sel_ipp   = paddr == `CMH_A_IPPEND;
  wire addr_ok   = sel_creq | sel_cmask | sel_mask | sel_arb | sel_mcon | sel_da
                 | sel_db | sel_txp | sel_ndp | sel_ipp;
  // Buffer writes during a transfer are dropped to keep it consistent
  wire ifw_ok    = acc & pwrite & ~busy;
  wire [NW-1:0] req_num = pwdata[NW-1:0];
  wire req_ok    = ifw_ok & sel_creq & (req_num != '0) & (req_num <= NW'(NOBJ));
  wire [31:0] creq_rd = {16'h0000, busy, {(15 - NW){1'b0}}, creq_num_r};
  wire [31:0] rd_word = sel_creq  ? creq_rd
                      : sel_cmask ? {24'h00_0000, cmask_r}
                      : sel_mask  ? ifb_r.mask
                      : sel_arb   ? ifb_r.arb
                      : sel_mcon  ? {16'h0000, ifb_r.mcon}
                      : sel_da    ? ifb_r.da
                      : sel_db    ? ifb_r.db
                      : sel_txp   ? 32'(txp)
                      : sel_ndp   ? 32'(ndv)
                      : sel_ipp   ? 32'(ipv)
                      : `CMH_RST_WORD;

  // -----------------------------------------------------------------------
  // Per-object compare and flag vectors
  // -----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NOBJ; g++)
    begin : g_obj
      cmh_match u_match
      (
        .obj (mem[g]),
        .frm (rx_r),
        .hit (hit[g])
      );
      assign txp[g]  = mem[g].arb[`CMH_AR_VALID] & mem[g].mcon[`CMH_MC_TRANSMIT_REQUEST];
      assign ndv[g]  = mem[g].mcon[`CMH_MC_NEW_DATA_FLAG];
      assign ipv[g]  = mem[g].mcon[`CMH_MC_INTERRUPT_PENDING_FLAG];
      // Member with unread data and no end mark is skipped
      assign elig[g] = hit[g] & ~(ndv[g] & ~mem[g].mcon[`CMH_MC_EOB]);
    end
  endgenerate

  wire [IW:0] tx_pick = first_set(txp);
  wire [IW:0] rx_pick = first_set(elig);

  // -----------------------------------------------------------------------
  // Operation select: one message RAM update per cycle
  // -----------------------------------------------------------------------
  // Start before done so the new-data check sees the cleared flag
  assign op = busy      ? cmh_pkg::OP_XFER
            : st_pend_r ? cmh_pkg::OP_START
            : dn_pend_r ? cmh_pkg::OP_DONE
            : rx_pend_r ? cmh_pkg::OP_RX
            : cmh_pkg::OP_NONE;
  assign idx = (op == cmh_pkg::OP_XFER) ? IW'(creq_num_r - NW'(1))
             : (op == cmh_pkg::OP_RX)   ? rx_pick[IW-1:0]
             : txo_r;
  assign cur = mem[idx];
  wire [28:0] rx_id_st = rx_r.xtd ? rx_r.id : {rx_r.id[28:18], 18'h0_0000};
  wire rx_found = rx_pick[IW];
  // Loading the core waits for a quiet message RAM
  wire tx_ok = (op == cmh_pkg::OP_NONE) & ~req_ok & ~inflight_r & ~tx_start & ~tx_done
             & ~tx_abort & ~rx_valid;

  // -----------------------------------------------------------------------
  // Next object contents
  // -----------------------------------------------------------------------
  always_comb
  begin
    nxt   = cur;
    wr_en = 1'b0;
    case (op)
      cmh_pkg::OP_XFER:
      begin
        wr_en = 1'b1;
        if (cmask_r[`CMH_CM_WR])
        begin
          // Selected parts rewritten; unselected parts keep stored values
          if (cmask_r[`CMH_CM_MASK]) nxt.mask = ifb_r.mask;
          if (cmask_r[`CMH_CM_ARB]) nxt.arb = ifb_r.arb;
          if (cmask_r[`CMH_CM_CTRL]) nxt.mcon = ifb_r.mcon;
          if (cmask_r[`CMH_CM_DA]) nxt.da = ifb_r.da;
          if (cmask_r[`CMH_CM_DB]) nxt.db = ifb_r.db;
          if (cmask_r[`CMH_CM_TXND]) nxt.mcon[`CMH_MC_TRANSMIT_REQUEST] = 1'b1;
        end
        else
        begin
          if (cmask_r[`CMH_CM_CLRIP]) nxt.mcon[`CMH_MC_INTERRUPT_PENDING_FLAG] = 1'b0;
          if (cmask_r[`CMH_CM_TXND]) nxt.mcon[`CMH_MC_NEW_DATA_FLAG] = 1'b0;
        end
      end
      cmh_pkg::OP_START:
      begin
        wr_en = 1'b1;
        nxt.mcon[`CMH_MC_NEW_DATA_FLAG] = 1'b0;
      end
      cmh_pkg::OP_DONE:
      begin
        wr_en = 1'b1;
        if (!cur.mcon[`CMH_MC_NEW_DATA_FLAG]) nxt.mcon[`CMH_MC_TRANSMIT_REQUEST] = 1'b0;
        if (cur.mcon[`CMH_MC_TRANSMIT_INT_ENABLE]) nxt.mcon[`CMH_MC_INTERRUPT_PENDING_FLAG] = 1'b1;
      end
      cmh_pkg::OP_RX:
      begin
        wr_en = rx_found;
        if (!rx_r.rtr)
        begin
          nxt.arb[28:0]             = rx_id_st;
          nxt.arb[`CMH_AR_XTD]      = rx_r.xtd;
          nxt.mcon[3:0]             = rx_r.dlc;
          nxt.da                    = rx_r.data[31:0];
          nxt.db                    = rx_r.data[63:32];
          nxt.mcon[`CMH_MC_NEW_DATA_FLAG]  = 1'b1;
          nxt.mcon[`CMH_MC_MESSAGE_LOST_FLAG]  = cur.mcon[`CMH_MC_MESSAGE_LOST_FLAG] | cur.mcon[`CMH_MC_NEW_DATA_FLAG];
          nxt.mcon[`CMH_MC_INTERRUPT_PENDING_FLAG]  = cur.mcon[`CMH_MC_INTERRUPT_PENDING_FLAG] | cur.mcon[`CMH_MC_RECEIVE_INT_ENABLE];
          nxt.mcon[`CMH_MC_TRANSMIT_REQUEST]  = 1'b0;
        end
        else if (cur.mcon[`CMH_MC_REMOTE_ANSWER_ENABLE])
          nxt.mcon[`CMH_MC_TRANSMIT_REQUEST]  = 1'b1;
        else if (cur.mcon[`CMH_MC_USE_ACCEPTANCE_MASK])
        begin
          // Masked remote frame handled like data; data bytes, lost and pending flags untouched
          nxt.arb[28:0]             = rx_id_st;
          nxt.arb[`CMH_AR_XTD]      = rx_r.xtd;
          nxt.mcon[3:0]             = rx_r.dlc;
          nxt.mcon[`CMH_MC_NEW_DATA_FLAG]  = 1'b1;
          nxt.mcon[`CMH_MC_TRANSMIT_REQUEST]  = 1'b0;
        end
      end
      default:
        wr_en = 1'b0;
    endcase
  end

  // Interface buffer: transfer result, else APB field write
  always_comb
  begin
    ifb_nxt = ifb_r;
    if (op == cmh_pkg::OP_XFER)
    begin
      if (cmask_r[`CMH_CM_WR])
        ifb_nxt = nxt;
      else
      begin
        // Flags copied as they stood before the clear
        if (cmask_r[`CMH_CM_MASK]) ifb_nxt.mask = cur.mask;
        if (cmask_r[`CMH_CM_ARB]) ifb_nxt.arb = cur.arb;
        if (cmask_r[`CMH_CM_CTRL]) ifb_nxt.mcon = cur.mcon;
        if (cmask_r[`CMH_CM_DA]) ifb_nxt.da = cur.da;
        if (cmask_r[`CMH_CM_DB]) ifb_nxt.db = cur.db;
      end
    end
    else if (ifw_ok)
    begin
      if (sel_mask) ifb_nxt.mask = pwdata;
      if (sel_arb) ifb_nxt.arb = pwdata;
      if (sel_mcon) ifb_nxt.mcon = pwdata[15:0];
      if (sel_da) ifb_nxt.da = pwdata;
      if (sel_db) ifb_nxt.db = pwdata;
    end
  end

  // -----------------------------------------------------------------------
  // Message RAM and interface registers
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < NOBJ; i++)
        mem[i] <= '0;
    else if (wr_en)
      mem[idx] <= nxt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ifb_r      <= '0;
      cmask_r    <= `CMH_RST_CMASK;
      creq_num_r <= '0;
      state_r    <= cmh_pkg::ST_IDLE;
    end
    else
    begin
      ifb_r      <= ifb_nxt;
      cmask_r    <= (ifw_ok & sel_cmask) ? pwdata[7:0] : cmask_r;
      creq_num_r <= req_ok ? req_num : creq_num_r;
      state_r    <= req_ok ? cmh_pkg::ST_BUSY : cmh_pkg::ST_IDLE;
    end
  end

  // APB answer: zero wait states, data loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= `CMH_RST_WORD;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r  <= setup ? rd_word : prdata_r;
      pready_r  <= 1'b1;
      pslverr_r <= setup ? ~addr_ok : pslverr_r;
    end
  end

  // -----------------------------------------------------------------------
  // Core events: set wins over the clear by the serving operation
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_pend_r  <= 1'b0;
      st_pend_r  <= 1'b0;
      dn_pend_r  <= 1'b0;
      inflight_r <= 1'b0;
      rx_r       <= '0;
      idx_q      <= '0;
    end
    else
    begin
      rx_pend_r  <= rx_valid | (rx_pend_r & (op != cmh_pkg::OP_RX));
      st_pend_r  <= tx_start | (st_pend_r & (op != cmh_pkg::OP_START));
      dn_pend_r  <= tx_done | (dn_pend_r & (op != cmh_pkg::OP_DONE));
      inflight_r <= tx_start | (inflight_r & ~tx_done & ~tx_abort);
      rx_r       <= rx_valid ? rx_frame : rx_r;
      idx_q      <= idx;
    end
  end

  // Transmit offer; frame frozen while the core holds it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_req_r   <= 1'b0;
      tx_frame_r <= '0;
      txo_r      <= '0;
      tx_num_r   <= '0;
    end
    else
    begin
      tx_req_r <= tx_ok & tx_pick[IW];
      if (tx_ok)
      begin
        tx_frame_r <= {mem[tx_pick[IW-1:0]].arb[28:0], mem[tx_pick[IW-1:0]].arb[`CMH_AR_XTD],
                       ~mem[tx_pick[IW-1:0]].arb[`CMH_AR_DIR], mem[tx_pick[IW-1:0]].mcon[3:0],
                       mem[tx_pick[IW-1:0]].db, mem[tx_pick[IW-1:0]].da};
        txo_r      <= tx_pick[IW-1:0];
        tx_num_r   <= NW'({1'b0, tx_pick[IW-1:0]} + NW'(1));
      end
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign tx_req   = tx_req_r;
  assign tx_frame = tx_frame_r;
  assign tx_obj   = tx_num_r;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rxd = (op == cmh_pkg::OP_RX) & rx_found & ~rx_r.rtr;
  wire [NOBJ-1:0] lowm = (NOBJ'(1) << txo_r) - NOBJ'(1);
  // Offered object as one-hot; txo_r moves on quiet cycles, so index it now
  wire [NOBJ-1:0] selm = NOBJ'(1) << txo_r;

  a_busy_single: assert property (req_ok |=> busy ##1 !busy)
    else $error("busy not exactly one cycle");
  a_tx_int_set: assert property (op == cmh_pkg::OP_DONE && cur.mcon[`CMH_MC_TRANSMIT_INT_ENABLE] |=> mem[idx_q].mcon[`CMH_MC_INTERRUPT_PENDING_FLAG])
    else $error("pending flag not set after transmit");
  a_done_hold: assert property (op == cmh_pkg::OP_DONE && cur.mcon[`CMH_MC_NEW_DATA_FLAG] |=> mem[idx_q].mcon[`CMH_MC_TRANSMIT_REQUEST] == $past(cur.mcon[`CMH_MC_TRANSMIT_REQUEST]))
    else $error("request dropped despite new data");
  a_start_clear: assert property (op == cmh_pkg::OP_START |=> !mem[idx_q].mcon[`CMH_MC_NEW_DATA_FLAG])
    else $error("new data not cleared at start");
  a_remote_answer: assert property (op == cmh_pkg::OP_RX && rx_found && rx_r.rtr && cur.mcon[`CMH_MC_REMOTE_ANSWER_ENABLE] |=> mem[idx_q].mcon[`CMH_MC_TRANSMIT_REQUEST])
    else $error("remote frame not answered");
  a_rx_int_set: assert property (rxd && cur.mcon[`CMH_MC_RECEIVE_INT_ENABLE] |=> mem[idx_q].mcon[`CMH_MC_INTERRUPT_PENDING_FLAG] && mem[idx_q].mcon[`CMH_MC_NEW_DATA_FLAG])
    else $error("receive flags not set");
  a_std_zero: assert property (rxd && !rx_r.xtd |=> mem[idx_q].arb[17:0] == 18'h0_0000)
    else $error("low identifier bits not zero");
  a_lost_flag: assert property ((rxd && cur.mcon[`CMH_MC_NEW_DATA_FLAG]) || (op != cmh_pkg::OP_XFER && op != cmh_pkg::OP_NONE && cur.mcon[`CMH_MC_MESSAGE_LOST_FLAG]) |=> mem[idx_q].mcon[`CMH_MC_MESSAGE_LOST_FLAG])
    else $error("lost flag wrong");
  a_fifo_lock: assert property (op == cmh_pkg::OP_RX && rx_found |-> !(cur.mcon[`CMH_MC_NEW_DATA_FLAG] && !cur.mcon[`CMH_MC_EOB]))
    else $error("locked member written");
  a_rx_cancel: assert property (rxd |=> !mem[idx_q].mcon[`CMH_MC_TRANSMIT_REQUEST])
    else $error("request kept after data frame");
  a_tx_prio: assert property (tx_req_r |-> ($past(txp) & lowm) == '0 && ($past(txp) & selm) != '0)
    else $error("transmit priority wrong");
  a_rd_clear: assert property (op == cmh_pkg::OP_XFER && !cmask_r[`CMH_CM_WR] && cmask_r[`CMH_CM_CLRIP] && cmask_r[`CMH_CM_CTRL] |=> !mem[idx_q].mcon[`CMH_MC_INTERRUPT_PENDING_FLAG] && ifb_r.mcon[`CMH_MC_INTERRUPT_PENDING_FLAG] == $past(cur.mcon[`CMH_MC_INTERRUPT_PENDING_FLAG]))
    else $error("read clear wrong");
  a_upd_set: assert property (op == cmh_pkg::OP_XFER && cmask_r[`CMH_CM_WR] && cmask_r[`CMH_CM_TXND] |=> mem[idx_q].mcon[`CMH_MC_TRANSMIT_REQUEST])
    else $error("update did not set request");

  c_remote: cover property (op == cmh_pkg::OP_RX && rx_found && rx_r.rtr && cur.mcon[`CMH_MC_REMOTE_ANSWER_ENABLE]);
  c_overwrite: cover property (rxd && cur.mcon[`CMH_MC_EOB] && cur.mcon[`CMH_MC_NEW_DATA_FLAG]);
  c_update: cover property (op == cmh_pkg::OP_XFER && cmask_r == 8'h87);
  c_read: cover property (op == cmh_pkg::OP_XFER && cmask_r == 8'h7f);

endmodule
